// >>> logic/mct_pkg.sv
// constants shared by the multi-channel timer core
package mct_pkg;
  localparam int NCH = 3;
  localparam int NGR = 4;

  // per-channel word address block: addr[4:3] = channel, addr[2:0] = sub-register
  localparam logic [2:0] SUB_CNT = 3'h0;
  localparam logic [2:0] SUB_GRA = 3'h1;
  localparam logic [2:0] SUB_GRB = 3'h2;
  localparam logic [2:0] SUB_GRC = 3'h3;
  localparam logic [2:0] SUB_GRD = 3'h4;
  localparam logic [2:0] SUB_PIO = 3'h5;
  localparam logic [2:0] SUB_CCR = 3'h6;
  localparam logic [2:0] SUB_STS = 3'h7;

  // global registers
  localparam logic [4:0] ADDR_RUN  = 5'h18;
  localparam logic [4:0] ADDR_SYNC = 5'h19;
  localparam logic [4:0] ADDR_MODE = 5'h1a;

  // reset values, counter maximum and channel mask
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] GR_RST  = 16'hffff;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [7:0]  REG_RST = 8'h00;
  localparam logic [2:0]  CH_MASK = 3'h7;

  // pin_io_control_reg fields, nibble per general register (A low, B high)
  localparam int PIO_CAP   = 0;
  localparam int PIO_LVL   = 1;
  localparam int PIO_INIT  = 2;
  localparam int PIO_BOTH  = 3;
  localparam int PIO_NIB   = 4;

  // clear_source_field encodings in count_control_reg bits 1:0
  localparam logic [1:0] CLR_NONE = 2'h0;
  localparam logic [1:0] CLR_A    = 2'h1;
  localparam logic [1:0] CLR_B    = 2'h2;
  localparam logic [1:0] CLR_SYNC = 2'h3;

  // status register: bits 3:0 match or capture flags a..d, bit 4 overflow
  localparam int STS_OVF = 4;
  localparam int STS_W   = 5;
endpackage

// >>> logic/mct_timer_core.sv
// three-channel 16-bit timer core with compare/capture, run control and lockstep
`timescale 1ns/1ns
`default_nettype none
module mct_timer_core
  import mct_pkg::*;
(
  // clock and reset
  input  wire logic                  sys_clk_i,
  input  wire logic                  rst_i,
  // register port
  input  wire logic [4:0]            bus_addr_i,
  input  wire logic                  bus_wr_i,
  input  wire logic                  bus_rd_i,
  input  wire logic [1:0]            bus_be_i,
  input  wire logic [15:0]           bus_wdata_i,
  output logic      [15:0]           bus_rdata_o,
  output logic                       bus_ack_o,
  // count clock events, one per channel, from the prescaler
  input  wire logic [mct_pkg::NCH-1:0] count_tick_i,
  // timer pins, A and B of each channel
  input  wire logic [mct_pkg::NCH-1:0] pin_a_i,
  input  wire logic [mct_pkg::NCH-1:0] pin_b_i,
  output logic      [mct_pkg::NCH-1:0] pin_a_o,
  output logic      [mct_pkg::NCH-1:0] pin_a_oe_o,
  output logic      [mct_pkg::NCH-1:0] pin_b_o,
  output logic      [mct_pkg::NCH-1:0] pin_b_oe_o
);
  import mct_pkg::*;

  // register state
  logic [15:0]        cnt_q   [NCH];
  logic [15:0]        cnt_d   [NCH];
  logic [15:0]        gr_q    [NCH][NGR];
  logic [15:0]        gr_d    [NCH][NGR];
  logic [7:0]         pio_q   [NCH];
  logic [7:0]         pio_d   [NCH];
  logic [7:0]         ccr_q   [NCH];
  logic [7:0]         ccr_d   [NCH];
  logic [STS_W-1:0]   sts_q   [NCH];
  logic [STS_W-1:0]   sts_d   [NCH];
  logic [STS_W-1:0]   arm_q   [NCH];
  logic [STS_W-1:0]   arm_d   [NCH];
  logic [1:0]         pin_q   [NCH];
  logic [1:0]         pin_d   [NCH];
  logic [NCH-1:0]     run_q;
  logic [NCH-1:0]     run_d;
  logic [NCH-1:0]     sync_q;
  logic [NCH-1:0]     sync_d;
  logic [1:0]         mode_q;
  logic [1:0]         mode_d;
  logic [15:0]        rdata_q;
  logic [15:0]        rdata_d;
  logic               ack_q;

  // pin edge detection
  logic [NCH-1:0]     edge_a;
  logic [NCH-1:0]     edge_b;

  // decoded events
  logic [NGR-1:0]     match   [NCH];
  logic [NGR-1:0]     capt    [NCH];
  logic [NCH-1:0]     clr_own;
  logic [NCH-1:0]     clr_sync;
  logic [NCH-1:0]     preset;

  // bus decode
  logic               word_acc;
  logic               byte_lo;
  logic               ch_hit;
  logic [1:0]         wch;
  logic [2:0]         sub;

  assign word_acc = &bus_be_i;
  assign byte_lo  = bus_be_i[0];
  assign wch      = bus_addr_i[4:3];
  assign sub      = bus_addr_i[2:0];
  // channel field 3 is the global register page, not a fourth channel
  assign ch_hit   = (wch != 2'h3);

  // pins come from outside: two flops, then a third for the edge
  genvar gc;
  generate
    for (gc = 0; gc < NCH; gc++) begin : g_pin
      logic [1:0] s1_q;
      logic [1:0] s2_q;
      logic [1:0] s3_q;
      always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
          s1_q <= 2'h0;
          s2_q <= 2'h0;
          s3_q <= 2'h0;
        end else begin
          s1_q <= {pin_b_i[gc], pin_a_i[gc]};
          s2_q <= s1_q;
          s3_q <= s2_q;
        end
      end
      // rising edge, or either edge when the both-edges bit is set
      assign edge_a[gc] = (s2_q[0] ^ s3_q[0]) & (s2_q[0] | pio_q[gc][PIO_BOTH]);
      assign edge_b[gc] = (s2_q[1] ^ s3_q[1]) & (s2_q[1] | pio_q[gc][PIO_NIB + PIO_BOTH]);
    end
  endgenerate

  // event decode: compare matches, captures and each channel's own clear
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      for (int g = 0; g < NGR; g++) begin
        match[c][g] = 1'b0;
        capt[c][g]  = 1'b0;
      end
      for (int g = 0; g < 2; g++) begin
        // match is taken at the counting edge so a halted counter never fires
        if (pio_q[c][g*PIO_NIB + PIO_CAP]) begin
          capt[c][g] = (g == 0) ? edge_a[c] : edge_b[c];
        end else begin
          match[c][g] = run_q[c] & count_tick_i[c] & (cnt_q[c] == gr_q[c][g]);
        end
      end
      // C and D exist on channel 0 only; as plain compare when not buffering
      if (c == 0) begin
        for (int g = 2; g < NGR; g++) begin
          match[c][g] = run_q[c] & count_tick_i[c] & ~mode_q[g-2] &
                        (cnt_q[c] == gr_q[c][g]);
        end
      end
      clr_own[c] = ((ccr_q[c][1:0] == CLR_A) & (match[c][0] | capt[c][0])) |
                   ((ccr_q[c][1:0] == CLR_B) & (match[c][1] | capt[c][1]));
    end
    for (int c = 0; c < NCH; c++) begin
      // another synchronised channel clearing pulls this one along
      clr_sync[c] = sync_q[c] & (ccr_q[c][1:0] == CLR_SYNC) &
                    |(clr_own & sync_q & ~(NCH'(1) << c));
      // a counter write on a synchronised channel presets all linked ones
      preset[c] = bus_wr_i & word_acc & ch_hit & (sub == SUB_CNT) &
                  ((int'(wch) == c) | (sync_q[c] & sync_q[wch]));
    end
  end

  // next state of the channel registers
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      logic            chw;
      logic            buf_on;
      logic [STS_W-1:0] setv;
      logic [STS_W-1:0] clrv;
      chw   = bus_wr_i & ch_hit & (int'(wch) == c);
      buf_on = 1'b0;
      setv  = '0;
      clrv  = '0;
      cnt_d[c] = cnt_q[c];
      pio_d[c] = pio_q[c];
      ccr_d[c] = ccr_q[c];
      arm_d[c] = arm_q[c];
      pin_d[c] = pin_q[c];
      for (int g = 0; g < NGR; g++) begin
        gr_d[c][g] = gr_q[c][g];
      end

      // counter: preset beats clear beats count
      if (preset[c]) begin
        cnt_d[c] = bus_wdata_i;
      end else if (clr_own[c] | clr_sync[c]) begin
        cnt_d[c] = CNT_RST;
      end else if (run_q[c] & count_tick_i[c]) begin
        cnt_d[c] = 16'(cnt_q[c] + 16'h0001);
        setv[STS_OVF] = (cnt_q[c] == CNT_MAX);
      end

      // general register writes need a whole word
      // c and d slots are absent on channels 1 and 2, so writes there fall away
      if (chw & word_acc) begin
        for (int g = 0; g < NGR; g++) begin
          if ((sub == 3'(int'(SUB_GRA) + g)) & ((c == 0) | (g < 2))) begin
            gr_d[c][g] = bus_wdata_i;
          end
        end
      end

      // hardware events land after the bus write so they are never lost
      for (int g = 0; g < 2; g++) begin
        buf_on = (c == 0) & mode_q[g];
        if (capt[c][g]) begin
          gr_d[c][g] = cnt_q[c];
          if (buf_on) begin
            gr_d[c][g+2] = gr_q[c][g];
          end
        end
        if (match[c][g] & buf_on) begin
          gr_d[c][g] = gr_q[c][g+2];
        end
        // output follows the match level; otherwise only a pio write while the channel is halted moves it
        if (match[c][g]) begin
          pin_d[c][g] = pio_q[c][g*PIO_NIB + PIO_LVL];
        end
      end
      for (int g = 0; g < NGR; g++) begin
        setv[g] = match[c][g] | capt[c][g];
      end

      // byte-wide control registers use the low lane
      if (chw & byte_lo & (sub == SUB_PIO)) begin
        pio_d[c] = bus_wdata_i[7:0];
        if (!run_q[c]) begin
          pin_d[c][0] = bus_wdata_i[PIO_INIT];
          pin_d[c][1] = bus_wdata_i[PIO_NIB + PIO_INIT];
        end
      end
      if (chw & byte_lo & (sub == SUB_CCR)) begin
        ccr_d[c] = bus_wdata_i[7:0];
      end

      // flags: read as 1 arms, later write of 0 clears; setting wins
      if (bus_rd_i & ch_hit & (int'(wch) == c) & (sub == SUB_STS)) begin
        arm_d[c] = sts_q[c];
      end
      if (chw & byte_lo & (sub == SUB_STS)) begin
        clrv     = arm_q[c] & ~bus_wdata_i[STS_W-1:0];
        arm_d[c] = '0;
      end
      if (c != 0) begin
        setv[3:2] = 2'h0;
      end
      sts_d[c] = (sts_q[c] & ~clrv) | setv;
    end
  end

  // global registers and read mux
  always_comb begin
    run_d   = run_q;
    sync_d  = sync_q;
    mode_d  = mode_q;
    // read data holds between reads, so a late sample still sees it
    rdata_d = rdata_q;
    if (bus_wr_i & byte_lo) begin
      if (bus_addr_i == ADDR_RUN) begin
        run_d = bus_wdata_i[NCH-1:0];
      end
      if (bus_addr_i == ADDR_SYNC) begin
        // reserved lockstep bits are not stored and read back zero
        sync_d = bus_wdata_i[NCH-1:0];
      end
      if (bus_addr_i == ADDR_MODE) begin
        mode_d = bus_wdata_i[1:0];
      end
    end
    if (bus_rd_i) begin
      rdata_d = 16'h0000;
      if (ch_hit) begin
        case (sub)
          SUB_CNT: rdata_d = cnt_q[wch];
          SUB_GRA: rdata_d = gr_q[wch][0];
          SUB_GRB: rdata_d = gr_q[wch][1];
          SUB_GRC: rdata_d = (wch == 2'h0) ? gr_q[0][2] : 16'h0000;
          SUB_GRD: rdata_d = (wch == 2'h0) ? gr_q[0][3] : 16'h0000;
          SUB_PIO: rdata_d = {8'h00, pio_q[wch]};
          SUB_CCR: rdata_d = {8'h00, ccr_q[wch]};
          SUB_STS: rdata_d = {11'h000, sts_q[wch]};
          default: rdata_d = 16'h0000;
        endcase
      end else begin
        case (bus_addr_i)
          ADDR_RUN:  rdata_d = {13'h0000, run_q};
          ADDR_SYNC: rdata_d = {13'h0000, sync_q};
          ADDR_MODE: rdata_d = {14'h0000, mode_q};
          default:   rdata_d = 16'h0000;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      for (int c = 0; c < NCH; c++) begin
        cnt_q[c] <= CNT_RST;
        pio_q[c] <= REG_RST;
        ccr_q[c] <= REG_RST;
        sts_q[c] <= '0;
        arm_q[c] <= '0;
        pin_q[c] <= 2'h0;
        for (int g = 0; g < NGR; g++) begin
          gr_q[c][g] <= GR_RST;
        end
      end
      run_q   <= '0;
      sync_q  <= '0;
      mode_q  <= 2'h0;
      rdata_q <= 16'h0000;
      ack_q   <= 1'b0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        cnt_q[c] <= cnt_d[c];
        pio_q[c] <= pio_d[c];
        ccr_q[c] <= ccr_d[c];
        sts_q[c] <= sts_d[c];
        arm_q[c] <= arm_d[c];
        pin_q[c] <= pin_d[c];
        for (int g = 0; g < NGR; g++) begin
          gr_q[c][g] <= gr_d[c][g];
        end
      end
      run_q   <= run_d;
      sync_q  <= sync_d;
      mode_q  <= mode_d;
      rdata_q <= rdata_d;
      // refused byte accesses are acked as well, so the master never waits forever
      ack_q   <= bus_rd_i | bus_wr_i;
    end
  end

  // outputs
  assign bus_rdata_o = rdata_q;
  assign bus_ack_o   = ack_q;
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      pin_a_o[c]    = pin_q[c][0];
      pin_b_o[c]    = pin_q[c][1];
      pin_a_oe_o[c] = ~pio_q[c][PIO_CAP];
      pin_b_oe_o[c] = ~pio_q[c][PIO_NIB + PIO_CAP];
    end
  end
endmodule
`default_nettype wire

// >>> tb/mct_timer_core_assertions.sv
// port-level checker for the timer core
`timescale 1ns/1ns
`default_nettype none
module mct_timer_core_assertions
  import mct_pkg::*;
(
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  input wire logic [4:0]  bus_addr_i,
  input wire logic        bus_wr_i,
  input wire logic        bus_rd_i,
  input wire logic [1:0]  bus_be_i,
  input wire logic [15:0] bus_wdata_i,
  input wire logic [15:0] bus_rdata_o,
  input wire logic        bus_ack_o,
  input wire logic [2:0]  pin_a_o,
  input wire logic [2:0]  pin_b_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // shadow copies of the 3-bit controls, tracked from bus writes alone
  logic [2:0]  run_q;
  logic [2:0]  sync_q;
  logic [15:0] wd_q;
  always_ff @(posedge sys_clk_i) begin
    wd_q <= bus_wdata_i;
    if (rst_i) begin
      run_q  <= '0;
      sync_q <= '0;
    end else if (bus_wr_i && bus_be_i[0]) begin
      if (bus_addr_i == ADDR_RUN) run_q <= bus_wdata_i[2:0];
      if (bus_addr_i == ADDR_SYNC) sync_q <= bus_wdata_i[2:0];
    end
  end
  wire logic rd_run = bus_rd_i && bus_addr_i == ADDR_RUN;
  wire logic rd_cd  = bus_rd_i && bus_addr_i[4:3] != 2'h0 && bus_addr_i[2:0] inside {3'h3, 3'h4};
  chk_ack_req: assert property ((bus_wr_i || bus_rd_i) |=> bus_ack_o)
    else $error("no ack after request");
  chk_ack_idle: assert property (!(bus_wr_i || bus_rd_i) |=> !bus_ack_o)
    else $error("ack without request");
  chk_run_rsv: assert property (rd_run |=> bus_rdata_o[15:3] == 13'h0000)
    else $error("run reserved bits not zero");
  chk_run_read: assert property (rd_run |=> bus_rdata_o[2:0] == run_q)
    else $error("run bits mismatch");
  chk_sync_read: assert property (bus_rd_i && bus_addr_i == ADDR_SYNC
    |=> bus_rdata_o[2:0] == sync_q)
    else $error("lockstep bits mismatch");
  chk_cd_absent: assert property (rd_cd |=> bus_rdata_o == 16'h0000)
    else $error("absent register not zero");
  chk_rdata_hold: assert property (!bus_rd_i |=> $stable(bus_rdata_o))
    else $error("read data moved");
  chk_pin_hold: assert property (run_q == 3'h0 && !bus_wr_i
    |=> $stable({pin_a_o, pin_b_o}))
    else $error("pin moved while halted");
  chk_pin_init: assert property (bus_wr_i && bus_be_i[0] && bus_addr_i == 5'h05 && !run_q[0]
    |=> pin_a_o[0] == wd_q[PIO_INIT])
    else $error("pin not at initial level");
  cov_run: cover property (bus_wr_i && bus_addr_i == ADDR_RUN && bus_wdata_i[0]);
  cov_pin_fall: cover property ($fell(pin_a_o[0]));
  cov_sync: cover property (sync_q == 3'h3 && bus_wr_i && bus_addr_i == 5'h00);
endmodule
bind mct_timer_core mct_timer_core_assertions u_chk (.sys_clk_i, .rst_i, .bus_addr_i,
  .bus_wr_i, .bus_rd_i, .bus_be_i, .bus_wdata_i, .bus_rdata_o, .bus_ack_o, .pin_a_o, .pin_b_o);
`default_nettype wire

// >>> tb/mct_bus_master.sv
// on-chip bus master model driving the register port
`timescale 1ns/1ns
`default_nettype none
module mct_bus_master (
  input  wire logic        sys_clk_i,
  input  wire logic [15:0] rdata_i,
  output logic [4:0]       addr_o,
  output logic             wr_o,
  output logic             rd_o,
  output logic [1:0]       be_o,
  output logic [15:0]      wdata_o
);
  initial begin
    {addr_o, wr_o, rd_o, be_o, wdata_o} = '0;
  end
  // one strobe cycle, then the answer one edge later
  task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d,
                     input logic [1:0] b, output logic [15:0] q);
    @(negedge sys_clk_i);
    addr_o  = a;
    wdata_o = d;
    be_o    = b;
    wr_o    = w;
    rd_o    = !w;
    @(negedge sys_clk_i);
    wr_o    = 1'b0;
    rd_o    = 1'b0;
    // released lines show the inverse so stale values never look live
    addr_o  = ~a;
    wdata_o = ~d;
    be_o    = ~b;
    @(posedge sys_clk_i);
    q = rdata_i;
  endtask
endmodule
`default_nettype wire

// >>> tb/mct_timer_core_tb_top.sv
// self-checking bench for the timer core
`timescale 1ns/1ns
`default_nettype none
module mct_timer_core_tb_top;
  import mct_pkg::*;
  logic        sys_clk, rst, wr, rd, ack;
  logic [4:0]  addr;
  logic [1:0]  be;
  logic [15:0] wdata, rdata, q, v, lf;
  logic [2:0]  tk, pa, pae, pb, pbe, pin_in;
  int          err_count, checks_done, n;
  mct_timer_core DUT (.sys_clk_i(sys_clk), .rst_i(rst), .bus_addr_i(addr), .bus_wr_i(wr),
    .bus_rd_i(rd), .bus_be_i(be), .bus_wdata_i(wdata), .bus_rdata_o(rdata), .bus_ack_o(ack),
    .count_tick_i(tk), .pin_a_i(pin_in), .pin_b_i(3'h0), .pin_a_o(pa), .pin_a_oe_o(pae),
    .pin_b_o(pb), .pin_b_oe_o(pbe));
  mct_bus_master bm (.sys_clk_i(sys_clk), .rdata_i(rdata), .addr_o(addr), .wr_o(wr),
    .rd_o(rd), .be_o(be), .wdata_o(wdata));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  function automatic logic [15:0] nxt();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic w(input logic [4:0] a, input logic [15:0] d);
    bm.acc(1'b1, a, d, 2'b11, q);
  endtask
  task automatic rdc(input string s, input logic [4:0] a, input logic [15:0] e);
    bm.acc(1'b0, a, 16'h0000, 2'b11, q);
    chk(s, e, q);
  endtask
  task automatic ticks(input int k);
    repeat (k) begin
      @(negedge sys_clk);
      tk = CH_MASK;
    end
    @(negedge sys_clk);
    tk = '0;
  endtask
  initial begin
    #2_000_000;
    err_count++;
    complete_run();
  end
  initial begin
    tk = '0;
    pin_in = '0;
    rst = 1'b1;
    lf = 16'hb54c;
    err_count = 0;
    checks_done = 0;
    repeat (20) @(negedge sys_clk);
    rst = 1'b0;
    for (int c = 0; c < 3; c++) begin
      rdc("cnt", 5'(c * 8), CNT_RST);
      rdc("gra", 5'(c * 8 + 1), GR_RST);
      rdc("grb", 5'(c * 8 + 2), GR_RST);
      rdc("grc", 5'(c * 8 + 3), c == 0 ? GR_RST : 16'h0000);
    end
    rdc("grd", SUB_GRD, GR_RST);
    rdc("run", ADDR_RUN, 16'h0000);
    rdc("sync", ADDR_SYNC, 16'h0000);
    chk("oe_rst", 16'h003f, {10'h000, pbe, pae});
    for (int i = 0; i < 6; i++) begin
      v = nxt();
      w(5'(i % 3 * 8 + 1 + i / 3), v);
      rdc("gr_rw", 5'(i % 3 * 8 + 1 + i / 3), v);
      bm.acc(1'b1, 5'(i % 3 * 8 + 1 + i / 3), ~v, 2'b01, q);
      rdc("gr_byte", 5'(i % 3 * 8 + 1 + i / 3), v);
    end
    bm.acc(1'b1, 5'h08, 16'h5555, 2'b10, q);
    rdc("cnt_byte", 5'h08, 16'h0000);
    w(ADDR_RUN, 16'h00f8);
    rdc("run_rsv", ADDR_RUN, 16'h0000);
    v = nxt();
    n = 10 + v[3:0];
    w(5'h00, v);
    w(ADDR_RUN, 16'h0001);
    ticks(n);
    w(ADDR_RUN, 16'h0000);
    rdc("count", 5'h00, v + 16'(n));
    rdc("halted", 5'h08, 16'h0000);
    w(5'h00, CNT_MAX);
    w(ADDR_RUN, 16'h0001);
    ticks(1);
    w(ADDR_RUN, 16'h0000);
    rdc("wrap", 5'h00, 16'h0000);
    w(SUB_STS, 16'h0000);
    bm.acc(1'b0, SUB_STS, 16'h0000, 2'b11, q);
    chk("ovf_kept", 16'h0010, q & 16'h0010);
    w(SUB_STS, 16'h0000);
    bm.acc(1'b0, SUB_STS, 16'h0000, 2'b11, q);
    chk("ovf_clr", 16'h0000, q & 16'h0010);
    w(ADDR_SYNC, 16'h0003);
    v = nxt();
    w(5'h00, v);
    rdc("preset", 5'h08, v);
    rdc("indep", 5'h10, 16'h0000);
    // counters are halted here, so clear sources may change
    w(SUB_GRA, 16'h0005);
    w(SUB_GRC, 16'h0009);
    w(ADDR_MODE, 16'h0001);
    w(SUB_CCR, 16'(CLR_A));
    w(5'h0e, 16'(CLR_SYNC));
    w(SUB_PIO, 16'h0044);
    chk("pin_init", 16'h0001, {15'h0, pa[0]});
    chk("pin_init_b", 16'h0001, {15'h0, pb[0]});
    w(5'h00, 16'h0000);
    w(ADDR_RUN, 16'h0003);
    ticks(7);
    w(ADDR_RUN, 16'h0000);
    rdc("c0_clr", 5'h00, 16'h0001);
    rdc("c1_clr", 5'h08, 16'h0001);
    rdc("buf_a", SUB_GRA, 16'h0009);
    repeat (5) @(negedge sys_clk);
    chk("pin_keep", 16'h0000, {15'h0, pa[0]});
    // channel 2 stays halted, so a capture must take the preset value
    v = nxt();
    w(5'h10, v);
    w(5'h15, 16'h0001);
    chk("cap_oe", 16'h003b, {10'h000, pbe, pae});
    @(negedge sys_clk);
    pin_in = 3'h4;
    repeat (4) @(negedge sys_clk);
    rdc("cap_a", 5'h11, v);
    rdc("cap_flag", 5'h17, 16'h0001);
    complete_run();
  end
endmodule
`default_nettype wire
